//--- core/sysconf_pkg.sv
// Function
// - The window spans 64KB; registers are full 32-bit aligned words.
// - Window offsets decode into system, bridge, other, peripheral regions.
// - Window base pointer bits 28:16 reset 0x1FFF; a write relocates it.
// - Crypto clock select bits 10:9 pick 200/166/125/50 MHz; reset 0x1.
// - Bit 7 picks PCI clock, one for 66 MHz, zero for 33 MHz.
// - Processor clock select bits 6:4 pick 250 down to 50 MHz; reset 0x4.
// - Memory clock select bits 3:2 pick 200/166/125/100 MHz; reset 0x3.
// - System bus clock select bits 1:0 pick 166/125/50 MHz; reset 0x2.
// - NAND bit 31 drives write-protect release directly; resets to one.
// - NAND bit 30 enables auto page open; reset from strap, stays writable.
// - NAND bank pointer bits 28:16 resets 0x1FFE in 64 KB units.
// - Crypto pointer bits 28:18 reset 0x7FE, 256 KB units; bit 0 enable.
// - Read-only bit 31 of pad register reports the PLL-bypass strap.
// - Read-only bit 30 reports bypass clock-select strap, 250 or 200 MHz.
// - Bits 19:16 enable four memory clock outputs; cleared holds low.
// - Bit 11 bypasses the deskew PLL when one; resets to zero.
// - Bypass delay select bits 9:8 choose one to four cells; reset 0x1.
// - Delay line bits 7:4 pick ten chains; reset 0x1; codes above 9 invalid.
// - Bit 2 powers down memory pad receivers when one; resets zero.
// - Feature bits 15:0 each disable one interface and gate its clock.
// - Static bank pointer bits 31:26 read-write; bits 25:0 read zero.
package sysconf_pkg;

   // Word offsets inside the system region.
   localparam logic [12:0] OFF_WINDOW_BASE  = 13'h0000;
   localparam logic [12:0] OFF_CLOCK_RATE   = 13'h0004;
   localparam logic [12:0] OFF_NAND_CFG     = 13'h0008;
   localparam logic [12:0] OFF_CRYPTO_CFG   = 13'h000C;
   localparam logic [12:0] OFF_FACTORY      = 13'h0010;
   localparam logic [12:0] OFF_DDR_PAD      = 13'h0014;
   localparam logic [12:0] OFF_FEATURE      = 13'h0018;
   localparam logic [12:0] OFF_STATIC_BASE  = 13'h001C;

   // Region boundaries, by offset bits 15:12.
   localparam int          REGION_COUNT     = 11;
   localparam logic [3:0]  REG_SYS_LAST     = 4'h1;
   localparam logic [3:0]  REG_PCI_LAST     = 4'h3;
   localparam logic [3:0]  REG_DDR          = 4'h4;
   localparam logic [3:0]  REG_SMC          = 4'h5;
   localparam logic [3:0]  REG_WDMA_LAST    = 4'h7;
   localparam logic [3:0]  REG_LDMA_LAST    = 4'h9;
   localparam logic [3:0]  REG_SDIO         = 4'hA;
   localparam logic [3:0]  REG_USBD         = 4'hB;
   localparam logic [3:0]  REG_EHCI         = 4'hC;
   localparam logic [3:0]  REG_OHCI         = 4'hD;

   // Window base fields.
   localparam int          WIN_LSB          = 16;
   localparam int          WIN_MSB          = 28;
   localparam logic [12:0] WIN_RESET        = 13'h1FFF;

   // Clock rate control fields.
   localparam int          CRYPTO_CLK_LSB   = 9;
   localparam logic [1:0]  CRYPTO_CLK_RESET = 2'h1;
   localparam int          FAST_MODE_BIT    = 8;
   localparam int          PCI_RATE_BIT     = 7;
   localparam int          CPU_CLK_LSB      = 4;
   localparam logic [2:0]  CPU_CLK_RESET    = 3'h4;
   localparam int          MEM_CLK_LSB      = 2;
   localparam logic [1:0]  MEM_CLK_RESET    = 2'h3;
   localparam int          SYS_CLK_LSB      = 0;
   localparam logic [1:0]  SYS_CLK_RESET    = 2'h2;

   // NAND bank fields.
   localparam int          PROTECT_BIT      = 31;
   localparam int          AUTO_PAGE_BIT    = 30;
   localparam int          NAND_PTR_LSB     = 16;
   localparam logic [12:0] NAND_PTR_RESET   = 13'h1FFE;

   // Crypto bank fields.
   localparam int          CRYPTO_PTR_LSB   = 18;
   localparam logic [10:0] CRYPTO_PTR_RESET = 11'h7FE;
   localparam int          CRYPTO_EN_BIT    = 0;

   // Memory delay and pad fields.
   localparam int          PLL_BYPASS_BIT   = 31;
   localparam int          BYP_CLKSEL_BIT   = 30;
   localparam int          MEM_CLKEN_LSB    = 16;
   localparam logic [3:0]  MEM_CLKEN_RESET  = 4'hF;
   localparam int          DESKEW_BYP_BIT   = 11;
   localparam int          BYP_DELAY_LSB    = 8;
   localparam logic [1:0]  BYP_DELAY_RESET  = 2'h1;
   localparam int          DELAY_LINE_LSB   = 4;
   localparam logic [3:0]  DELAY_LINE_RESET = 4'h1;
   localparam logic [3:0]  DELAY_LINE_MAX   = 4'h9;
   localparam int          PAD_PWD_BIT      = 2;

   // Feature disable and static bank fields.
   localparam logic [15:0] FEATURE_RESET    = 16'h0000;
   localparam int          STATIC_PTR_LSB   = 26;
   localparam logic [5:0]  STATIC_PTR_RESET = 6'h3F;

   // Strap capture: cycles waited after reset release before sampling.
   localparam logic [1:0]  STRAP_SETTLE     = 2'h3;

endpackage

//--- core/strap_capture.sv
`timescale 1ns/10ps
// Synchronises the strap pins and latches them once after power-on reset.
module strap_capture #(
   parameter int WIDTH = 3
) (
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] strapPins,
   output logic      [WIDTH-1:0] strapValue,
   output logic                  strapLoad,
   output logic                  strapDone
);

   logic [WIDTH-1:0] syncFirst;
   logic [WIDTH-1:0] syncSecond;
   logic [1:0]       settleCount;
   logic             settled;

   // Two-flop synchroniser; the first stage feeds only the second.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         syncFirst  <= '0;
         syncSecond <= '0;
      end else begin
         syncFirst  <= strapPins;
         syncSecond <= syncFirst;
      end
   end

   assign settled = (settleCount == sysconf_pkg::STRAP_SETTLE);

   // Sampled once, after the synchroniser has filled, then frozen.
   // The load pulse rises with the capture and the bank copies at the next edge,
   // so it takes the captured value and not the reset value; done rises with the copy.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         settleCount <= 2'h0;
         strapValue  <= '0;
         strapLoad   <= 1'b0;
         strapDone   <= 1'b0;
      end else if (!settled) begin
         settleCount <= settleCount + 2'h1;
      end else if (strapLoad) begin
         strapLoad <= 1'b0;
         strapDone <= 1'b1;
      end else if (!strapDone) begin
         strapValue <= syncSecond;
         strapLoad  <= 1'b1;
      end
   end

endmodule

//--- core/system_config_register_bank.sv
`timescale 1ns/10ps
// System configuration bank at the bottom of the relocatable window.
module system_config_register_bank (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        regReq,
   input  wire logic        regWrite,
   input  wire logic [31:0] regAddr,
   input  wire logic [31:0] regWdata,
   output logic      [31:0] regRdata,
   output logic             regAck,
   output logic             windowHit,
   output logic [10:0]      regionSelect,
   input  wire logic        autoPageStrap,
   input  wire logic        pllBypassStrap,
   input  wire logic        bypassClkSelStrap,
   output logic             strapReady,
   output logic [12:0]      windowBasePointer,
   output logic [1:0]       cryptoClockSelect,
   output logic             simFastMode,
   output logic             pciRateSelect,
   output logic [2:0]       cpuClockSelect,
   output logic [1:0]       memoryClockSelect,
   output logic [1:0]       systemClockSelect,
   output logic             nandProtectRelease,
   output logic             autoPageOpenEnable,
   output logic [12:0]      nandBankPointer,
   output logic [10:0]      cryptoBankPointer,
   output logic             cryptoEnable,
   output logic             pllBypass,
   output logic             bypassClockSelect,
   output logic [3:0]       memoryClockEnable,
   output logic             deskewBypass,
   output logic [1:0]       bypassDelaySelect,
   output logic [3:0]       delayLineSelect,
   output logic             padPowerDown,
   output logic [15:0]      featureDisable,
   output logic [15:0]      blockClockEnable,
   output logic [5:0]       staticBankPointer
);

   // Region index for window offset bits 15:12.
   function automatic logic [10:0] region_decode(input logic [3:0] nib);
      logic [10:0] sel;
      sel = 11'h000;
      if (nib <= sysconf_pkg::REG_SYS_LAST) begin
         sel[0] = 1'b1;
      end else if (nib <= sysconf_pkg::REG_PCI_LAST) begin
         sel[1] = 1'b1;
      end else if (nib == sysconf_pkg::REG_DDR) begin
         sel[2] = 1'b1;
      end else if (nib == sysconf_pkg::REG_SMC) begin
         sel[3] = 1'b1;
      end else if (nib <= sysconf_pkg::REG_WDMA_LAST) begin
         sel[4] = 1'b1;
      end else if (nib <= sysconf_pkg::REG_LDMA_LAST) begin
         sel[5] = 1'b1;
      end else if (nib == sysconf_pkg::REG_SDIO) begin
         sel[6] = 1'b1;
      end else if (nib == sysconf_pkg::REG_USBD) begin
         sel[7] = 1'b1;
      end else if (nib == sysconf_pkg::REG_EHCI) begin
         sel[8] = 1'b1;
      end else if (nib == sysconf_pkg::REG_OHCI) begin
         sel[9] = 1'b1;
      end else begin
         sel[10] = 1'b1;
      end
      return sel;
   endfunction

   logic [2:0]  strapValue;
   logic        strapLoad;
   logic        sysHit;
   logic        wrHit;
   logic [12:0] sysOffset;
   logic        selWindow;
   logic        selClock;
   logic        selNand;
   logic        selCrypto;
   logic        selPad;
   logic        selFeature;
   logic        selStatic;
   logic        delayValid;
   logic [31:0] readWindow;
   logic [31:0] readClock;
   logic [31:0] readNand;
   logic [31:0] readCrypto;
   logic [31:0] readPad;
   logic [31:0] readFeature;
   logic [31:0] readStatic;
   logic [31:0] next_rdata;

   // Straps are pins: synchronised and latched once in the helper.
   strap_capture #(
      .WIDTH (3)
   ) u_strap (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .strapPins  ({bypassClkSelStrap, pllBypassStrap, autoPageStrap}),
      .strapValue (strapValue),
      .strapLoad  (strapLoad),
      .strapDone  (strapReady)
   );

   // The window is 64KB at the programmed base; upper bits must be zero.
   assign windowHit = regReq && (regAddr[31:29] == 3'h0)
                      && (regAddr[28:16] == windowBasePointer);
   assign regionSelect = windowHit ? region_decode(regAddr[15:12])
                                   : 11'h000;
   assign sysHit    = regionSelect[0];
   assign sysOffset = {regAddr[12:2], 2'b00};
   assign wrHit     = sysHit && regWrite;

   // Register selects inside the system region.
   assign selWindow  = (sysOffset == sysconf_pkg::OFF_WINDOW_BASE);
   assign selClock   = (sysOffset == sysconf_pkg::OFF_CLOCK_RATE);
   assign selNand    = (sysOffset == sysconf_pkg::OFF_NAND_CFG);
   assign selCrypto  = (sysOffset == sysconf_pkg::OFF_CRYPTO_CFG);
   assign selPad     = (sysOffset == sysconf_pkg::OFF_DDR_PAD);
   assign selFeature = (sysOffset == sysconf_pkg::OFF_FEATURE);
   assign selStatic  = (sysOffset == sysconf_pkg::OFF_STATIC_BASE);

   // Invalid delay codes are refused so the chain never sees them.
   assign delayValid = (regWdata[7:4] <= sysconf_pkg::DELAY_LINE_MAX);

   // Window base register; a write moves the window from the next cycle.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         windowBasePointer <= sysconf_pkg::WIN_RESET;
      end else if (wrHit && selWindow) begin
         windowBasePointer <= regWdata[28:16];
      end
   end

   // Clock rate control register.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cryptoClockSelect <= sysconf_pkg::CRYPTO_CLK_RESET;
         simFastMode       <= 1'b0;
         pciRateSelect     <= 1'b0;
         cpuClockSelect    <= sysconf_pkg::CPU_CLK_RESET;
         memoryClockSelect <= sysconf_pkg::MEM_CLK_RESET;
         systemClockSelect <= sysconf_pkg::SYS_CLK_RESET;
      end else if (wrHit && selClock) begin
         cryptoClockSelect <= regWdata[10:9];
         simFastMode       <= regWdata[8];
         pciRateSelect     <= regWdata[7];
         cpuClockSelect    <= regWdata[6:4];
         memoryClockSelect <= regWdata[3:2];
         systemClockSelect <= regWdata[1:0];
      end
   end

   // NAND config; the strap load yields to a software write that cycle.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         nandProtectRelease <= 1'b1;
         autoPageOpenEnable <= 1'b0;
         nandBankPointer    <= sysconf_pkg::NAND_PTR_RESET;
      end else if (wrHit && selNand) begin
         nandProtectRelease <= regWdata[31];
         autoPageOpenEnable <= regWdata[30];
         nandBankPointer    <= regWdata[28:16];
      end else if (strapLoad) begin
         autoPageOpenEnable <= strapValue[0];
      end
   end

   // Crypto bank config.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cryptoBankPointer <= sysconf_pkg::CRYPTO_PTR_RESET;
         cryptoEnable      <= 1'b1;
      end else if (wrHit && selCrypto) begin
         cryptoBankPointer <= regWdata[28:18];
         cryptoEnable      <= regWdata[0];
      end
   end

   // Memory delay line and pad config.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         memoryClockEnable <= sysconf_pkg::MEM_CLKEN_RESET;
         deskewBypass      <= 1'b0;
         bypassDelaySelect <= sysconf_pkg::BYP_DELAY_RESET;
         delayLineSelect   <= sysconf_pkg::DELAY_LINE_RESET;
         padPowerDown      <= 1'b0;
      end else if (wrHit && selPad) begin
         memoryClockEnable <= regWdata[19:16];
         deskewBypass      <= regWdata[11];
         bypassDelaySelect <= regWdata[9:8];
         padPowerDown      <= regWdata[2];
         if (delayValid) begin
            delayLineSelect <= regWdata[7:4];
         end
      end
   end

   // Feature disable and static bank base.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         featureDisable    <= sysconf_pkg::FEATURE_RESET;
         staticBankPointer <= sysconf_pkg::STATIC_PTR_RESET;
      end else begin
         if (wrHit && selFeature) begin
            featureDisable <= regWdata[15:0];
         end
         if (wrHit && selStatic) begin
            staticBankPointer <= regWdata[31:26];
         end
      end
   end

   // The PLL-bypass and clock-select straps are read-only and frozen after the single capture.
   assign pllBypass         = strapValue[1];
   assign bypassClockSelect = strapValue[2];
   assign blockClockEnable  = ~featureDisable;

   // Read images; every reserved bit is a constant zero.
   assign readWindow  = {3'h0, windowBasePointer, 16'h0000};
   assign readClock   = {21'h000000, cryptoClockSelect, simFastMode,
                         pciRateSelect, cpuClockSelect, memoryClockSelect,
                         systemClockSelect};
   assign readNand    = {nandProtectRelease, autoPageOpenEnable, 1'b0,
                         nandBankPointer, 16'h0000};
   assign readCrypto  = {3'h0, cryptoBankPointer, 17'h00000, cryptoEnable};
   assign readPad     = {pllBypass, bypassClockSelect, 10'h000,
                         memoryClockEnable, 4'h0, deskewBypass, 1'b0,
                         bypassDelaySelect, delayLineSelect, 1'b0,
                         padPowerDown, 2'h0};
   assign readFeature = {16'h0000, featureDisable};
   assign readStatic  = {staticBankPointer, 26'h0000000};

   // Unmapped and factory offsets read as zero.
   assign next_rdata = regWrite   ? 32'h00000000 :
                       selWindow  ? readWindow  :
                       selClock   ? readClock   :
                       selNand    ? readNand    :
                       selCrypto  ? readCrypto  :
                       selPad     ? readPad     :
                       selFeature ? readFeature :
                       selStatic  ? readStatic  : 32'h00000000;

   // One-cycle answer to every access of the system region.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         regAck   <= 1'b0;
         regRdata <= 32'h00000000;
      end else begin
         regAck <= sysHit;
         if (sysHit) begin
            regRdata <= next_rdata;
         end
      end
   end

endmodule

//--- dv/system_config_register_bank_properties.sv
`timescale 1ns/10ps
// Port-level checks of the configuration bank; one clock domain only.
module system_config_register_bank_properties (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        regReq,
   input wire logic        regWrite,
   input wire logic [31:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic        regAck,
   input wire logic        windowHit,
   input wire logic [10:0] regionSelect,
   input wire logic        strapReady,
   input wire logic [12:0] windowBasePointer,
   input wire logic        nandProtectRelease,
   input wire logic        pllBypass,
   input wire logic [3:0]  delayLineSelect,
   input wire logic [15:0] featureDisable,
   input wire logic [15:0] blockClockEnable
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   // Qualified accesses; $past takes a signal, so fields are split out.
   wire        sysHit = regReq && regionSelect[0];
   wire        lowHit = windowHit && regAddr[15:13] == 3'h0;
   wire        pciHit = windowHit && regAddr[15:13] == 3'h1;
   wire        topHit = windowHit && regAddr[15:13] == 3'h7;
   wire        wrBase = sysHit && regWrite && regAddr[12:2] == 11'h000;
   wire        wrNand = sysHit && regWrite && regAddr[12:2] == 11'h002;
   wire [12:0] wdBase = regWdata[28:16];
   wire        wdTop  = regWdata[31];

   a_ack_follows:
      assert property (sysHit |=> regAck)
      else $error("access not acknowledged");
   a_ack_cause:
      assert property (regAck |-> $past(sysHit))
      else $error("ack without access");
   a_hit_decode:
      assert property (windowHit == (regReq
         && regAddr[31:16] == {3'h0, windowBasePointer}))
      else $error("window decode wrong");
   a_sys_region:
      assert property (lowHit |-> regionSelect == 11'h001)
      else $error("system region wrong");
   a_pci_region:
      assert property (pciHit |-> regionSelect == 11'h002)
      else $error("bridge region wrong");
   a_periph_region:
      assert property (topHit |-> regionSelect == 11'h400)
      else $error("peripheral region wrong");
   a_idle_region:
      assert property (!windowHit |-> regionSelect == 11'h000)
      else $error("region set without hit");
   a_base_write:
      assert property (wrBase |=> windowBasePointer == $past(wdBase))
      else $error("base pointer not updated");
   a_protect_write:
      assert property (wrNand |=> nandProtectRelease == $past(wdTop))
      else $error("protect output not updated");
   a_delay_valid:
      assert property (delayLineSelect <= 4'h9)
      else $error("invalid delay code held");
   a_clock_gate:
      assert property (blockClockEnable == ~featureDisable)
      else $error("clock gate mismatch");
   a_strap_held:
      assert property (strapReady && $past(strapReady) |-> $stable(pllBypass))
      else $error("strap bit changed");
   a_ready_sticky:
      assert property (strapReady |=> strapReady)
      else $error("strap ready dropped");

   c_base_write: cover property (wrBase);
   c_nand_write: cover property (wrNand);
   c_periph_hit: cover property (topHit);
endmodule

bind system_config_register_bank system_config_register_bank_properties
   system_config_register_bank_properties_i (.*);

//--- dv/cpu_bus_model.sv
`timescale 1ns/10ps
// Processor side of the register port: one word access at a time.
module cpu_bus_model (
   input  wire logic        clk_sys,
   output logic             regReq,
   output logic             regWrite,
   output logic [31:0]      regAddr,
   output logic [31:0]      regWdata,
   input  wire logic [31:0] regRdata,
   input  wire logic        regAck
);
   // Idle bus at time zero.
   initial begin
      regReq = 1'b0;
      regWrite = 1'b0;
      regAddr = 32'h00000000;
      regWdata = 32'h00000000;
   end

   // Pulses a request for one cycle, then waits a bounded time for the ack.
   task automatic access(input logic wr, input logic [31:0] addr, data,
                         output logic [31:0] rd, output logic ok);
      logic [31:0] d;
      d = data;
      if (addr[15:0] == 16'h0004)
         d[8] = 1'b0;
      ok = 1'b0;
      rd = 32'h00000000;
      @(posedge clk_sys);
      regReq <= 1'b1;
      regWrite <= wr;
      regAddr <= {addr[31:2], 2'h0};
      regWdata <= d;
      @(posedge clk_sys);
      // Taken at this edge; released lines show the inverse so stale data
      // cannot pass. The answer is sampled at a later rising edge.
      regReq <= 1'b0;
      regAddr <= ~addr;
      regWdata <= ~d;
      repeat (2) begin
         @(posedge clk_sys);
         if (regAck === 1'b1 && !ok) begin
            ok = 1'b1;
            rd = regRdata;
         end
      end
   endtask
endmodule

//--- dv/tb_top.sv
`timescale 1ns/10ps
// Self-checking bench for the configuration bank.
module tb_top;
   logic        clk_sys, rst, regReq, regWrite, regAck, windowHit;
   logic        strapReady, simFastMode, pciRateSelect, nandProtectRelease;
   logic        autoPageOpenEnable, cryptoEnable, pllBypass, padPowerDown;
   logic        bypassClockSelect, deskewBypass, autoPageStrap;
   logic        pllBypassStrap, bypassClkSelStrap;
   logic [1:0]  cryptoClockSelect, memoryClockSelect, systemClockSelect;
   logic [1:0]  bypassDelaySelect;
   logic [2:0]  cpuClockSelect;
   logic [3:0]  memoryClockEnable, delayLineSelect;
   logic [5:0]  staticBankPointer;
   logic [10:0] regionSelect, cryptoBankPointer;
   logic [12:0] windowBasePointer, nandBankPointer;
   logic [15:0] featureDisable, blockClockEnable;
   logic [31:0] regAddr, regWdata, regRdata, base;
   int          bad_count, check_count;
   // Offsets, then expected words after reset, all-ones and all-zeros.
   logic [31:0] offs [9] = '{32'h0, 32'h4, 32'h8, 32'hC, 32'h10, 32'h14,
                             32'h18, 32'h1C, 32'h20};
   logic [31:0] rstExp [9] = '{32'h1FFF0000, 32'h24E, 32'hDFFE0000,
      32'h1FF80001, 32'h0, 32'h800F0110, 32'h0, 32'hFC000000, 32'h0};
   logic [31:0] oneExp [9] = '{32'h0, 32'h6FF, 32'hDFFF0000, 32'h1FFC0001,
      32'h0, 32'h800F0B14, 32'hFFFF, 32'hFC000000, 32'h0};
   logic [31:0] zeroExp [9] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
      32'h80000000, 32'h0, 32'h0, 32'h0};

   system_config_register_bank system_config_register_bank_i (.*);
   cpu_bus_model cpu_bus_model_i (.*);

   // Clock at 200 MHz.
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   task automatic chk_word(input logic [31:0] got, exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_flag(input logic got, exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [31:0] off, d);
      logic [31:0] r;
      logic        ok;
      cpu_bus_model_i.access(1'b1, base + off, d, r, ok);
      chk_flag(ok, 1'b1);
   endtask

   task automatic rdchk(input logic [31:0] off, exp);
      logic [31:0] r;
      logic        ok;
      cpu_bus_model_i.access(1'b0, base + off, 32'h0, r, ok);
      chk_flag(ok, 1'b1);
      chk_word(r, exp);
   endtask

   task automatic t_reset;
      chk_flag(strapReady, 1'b1);
      chk_flag(autoPageOpenEnable, 1'b1);
      chk_flag(bypassClockSelect, 1'b0);
      for (int i = 0; i < 9; i++)
         rdchk(offs[i], rstExp[i]);
      $display("reset test done");
   endtask

   // Writes all ones then all zeros; reserved bits must stay zero.
   task automatic t_fields;
      for (int p = 0; p < 2; p++) begin
         for (int i = 1; i < 9; i++)
            wr(offs[i], p == 0 ? 32'hFFFFFFFF : 32'h0);
         for (int i = 1; i < 9; i++)
            rdchk(offs[i], p == 0 ? oneExp[i] : zeroExp[i]);
         chk_flag(nandProtectRelease, p == 0);
         chk_word({nandBankPointer, cryptoBankPointer, staticBankPointer,
                   2'h0}, p == 0 ? 32'hFFFFFFFC : 32'h0);
         chk_word({featureDisable, blockClockEnable},
                  p == 0 ? 32'hFFFF0000 : 32'hFFFF);
         chk_word({19'h0, memoryClockEnable, deskewBypass, bypassDelaySelect,
                   delayLineSelect, padPowerDown, cryptoEnable},
                  p == 0 ? 32'h1FC7 : 32'h0);
      end
      $display("field test done");
   endtask

   task automatic t_codes;
      logic [31:0] v;
      for (int i = 0; i < 5; i++) begin
         v = (i % 4) << 9 | (i % 2) << 7 | i << 4 | (i % 4) << 2 | i % 3;
         wr(32'h4, v);
         chk_word({21'h0, cryptoClockSelect, simFastMode, pciRateSelect,
                   cpuClockSelect, memoryClockSelect, systemClockSelect},
                  v);
      end
      // Codes above nine are refused and leave the previous code.
      for (int c = 0; c < 16; c++) begin
         wr(32'h14, c << 4);
         chk_word({28'h0, delayLineSelect}, c > 9 ? 9 : c);
      end
      $display("code test done");
   endtask

   task automatic t_window;
      logic [31:0] r;
      logic        ok;
      for (int n = 0; n < 16; n++) begin
         cpu_bus_model_i.access(1'b0, base + (n << 12), 32'h0, r, ok);
         chk_flag(ok, n < 2);
      end
      wr(32'h0, 32'h01230000);
      cpu_bus_model_i.access(1'b0, base + 32'h4, 32'h0, r, ok);
      chk_flag(ok, 1'b0);
      base = 32'h01230000;
      rdchk(32'h0, 32'h01230000);
      chk_word({19'h0, windowBasePointer}, 32'h0123);
      wr(32'h0, 32'hFFFFFFFF);
      base = 32'h1FFF0000;
      rdchk(32'h0, 32'h1FFF0000);
      $display("window test done");
   endtask

   // Later strap pin changes must not reach the captured bits.
   task automatic t_strap;
      @(posedge clk_sys);
      pllBypassStrap <= 1'b0;
      bypassClkSelStrap <= 1'b1;
      autoPageStrap <= 1'b0;
      repeat (8) @(posedge clk_sys);
      rdchk(32'h14, 32'h80000090);
      chk_flag(pllBypass, 1'b1);
      $display("strap test done");
   endtask

   task automatic complete_run;
      $display("checks=%0d mismatches=%0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      complete_run();
   end

   initial begin
      rst = 1'b1;
      autoPageStrap = 1'b1;
      pllBypassStrap = 1'b1;
      bypassClkSelStrap = 1'b0;
      base = 32'h1FFF0000;
      bad_count = 0;
      check_count = 0;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (6) @(posedge clk_sys);
      t_reset();
      t_fields();
      t_codes();
      t_window();
      t_strap();
      complete_run();
   end
endmodule
